// *** src/spc_pkg.sv ***
package spc_pkg;

  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_PROTECT = 8'h04;
  localparam logic [7:0] OFS_SERVICE = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Configuration, bits 15..0
  typedef struct packed {
    logic rsvd15;
    logic freeze_watchdog;
    logic freeze_monitor;
    logic pipeline_pins_disable;
    logic tester_slave_status;
    logic rsvd10;
    logic [1:0] show_cycle_select;
    logic supervisor_restrict;
    logic register_block_map;
    logic low_address_disable;
    logic direction_pin_disable;
    logic [3:0] arbitration_number;
  } spc_config_s;

  // Protection, bits 7..0
  typedef struct packed {
    logic watchdog_enable;
    logic watchdog_prescale;
    logic [1:0] watchdog_timing;
    logic halt_reset_enable;
    logic external_monitor_enable;
    logic [1:0] monitor_timeout_select;
  } spc_protect_s;

  // Status, bits 3..0
  typedef struct packed {
    logic [1:0] active_timing;
    logic service_armed;
    logic watchdog_expired;
  } spc_status_s;

  // Strap-dependent bits read zero until sampled after reset
  localparam logic [15:0] CONFIG_RST = 16'h00cf;
  localparam logic [7:0] PROTECT_RST = 8'h00;

  // Show cycle encodings
  localparam logic [1:0] SHOW_NONE = 2'h0;
  localparam logic [1:0] SHOW_NO_ARB = 2'h1;
  localparam logic [1:0] SHOW_HALT_GRANT = 2'h3;

  // Bus monitor limits in system clocks
  localparam logic [6:0] BM_LIMIT_00 = 7'h40;
  localparam logic [6:0] BM_LIMIT_01 = 7'h20;
  localparam logic [6:0] BM_LIMIT_10 = 7'h10;
  localparam logic [6:0] BM_LIMIT_11 = 7'h08;

  // Watchdog service keys
  localparam logic [7:0] SVC_KEY_ARM = 8'h55;
  localparam logic [7:0] SVC_KEY_FIRE = 8'haa;

  // Watchdog divider end counts
  localparam logic [6:0] DIV128_LAST = 7'h7f;
  localparam logic [8:0] DIV512_LAST = 9'h1ff;
  localparam logic [14:0] WDG_MASK_00 = 15'h01ff;
  localparam logic [14:0] WDG_MASK_01 = 15'h07ff;
  localparam logic [14:0] WDG_MASK_10 = 15'h1fff;
  localparam logic [14:0] WDG_MASK_11 = 15'h7fff;

  typedef enum logic {SVC_IDLE, SVC_ARMED} spc_svc_e;

endpackage

// *** src/spc_wdg_div.sv ***
`timescale 1ns/1ns
module spc_wdg_div (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_clear,
  input wire logic i_step,
  input wire logic i_high_freq,
  input wire logic i_prescale,
  input wire logic [1:0] i_timing,
  output logic o_expire
);
  logic [6:0] div128_ff;
  logic [8:0] div512_ff;
  logic [14:0] main_ff;
  logic [14:0] mask;
  logic hf_tick;
  logic pre_tick;

  // Optional 128, optional 512, then timing
  assign hf_tick = i_high_freq ?
    (i_step & (div128_ff == spc_pkg::DIV128_LAST)) : i_step;
  assign pre_tick = i_prescale ?
    (hf_tick & (div512_ff == spc_pkg::DIV512_LAST)) : hf_tick;

  // Timeout point chosen by the active timing field
  always_comb begin
    case (i_timing)
      2'h0: mask = spc_pkg::WDG_MASK_00;
      2'h1: mask = spc_pkg::WDG_MASK_01;
      2'h2: mask = spc_pkg::WDG_MASK_10;
      default: mask = spc_pkg::WDG_MASK_11;
    endcase
  end

  // Counters hold while frozen since no step arrives
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      div128_ff <= 7'h00;
      div512_ff <= 9'h000;
      main_ff <= 15'h0000;
    end else if (i_clear) begin
      div128_ff <= 7'h00;
      div512_ff <= 9'h000;
      main_ff <= 15'h0000;
    end else begin
      if (i_step && i_high_freq) begin
        div128_ff <= div128_ff + 7'h01;
      end
      if (hf_tick && i_prescale) begin
        div512_ff <= div512_ff + 9'h001;
      end
      if (pre_tick) begin
        main_ff <= main_ff + 15'h0001;
      end
    end
  end

  // Pulse at end of count
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_expire <= 1'b0;
    end else begin
      o_expire <= ~i_clear & pre_tick & ((main_ff & mask) == mask);
    end
  end
endmodule

// *** src/spc_top.sv ***
// Function
// - Pipeline pins float when disabled, except freeze
// - Three pin disables strap from bus-error pin
// - Slave status read-only, inverse data line eleven
// - Show-cycle field selects show and arbitration
// - Restrict bit blocks user accesses
// - Map bit picks register block base
// - Map bit takes only first write
// - Low address pins float when disabled
// - Direction pin floats when disabled
// - Arbitration number resets to all ones
// - Bus monitor times long cycles, flags error
// - Monitor limit 64, 32, 16, 8 clocks
// - External cycles watched only if processor, enabled
// - Halt on bus resets when enabled
// - No arbitration in acknowledge gives bus error
// - Spurious monitor cannot be disabled
// - Unserviced enabled watchdog asserts external reset
// - Prescale bit divides crystal by 512
// - Timing field divides by 2^9..2^15
// - High-frequency parts predivide crystal by 128
// - Prescale bit straps from clock-mode pin
// - Freeze can stop bus monitor
// - Freeze can stop watchdog count
// - New timing active after service sequence
`timescale 1ns/1ns
module spc_top #(
  parameter bit HIGH_FREQ_XTAL = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  input wire logic [2:0] i_arprot,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_bus_error_signal,
  input wire logic i_data_line_eleven,
  input wire logic i_clock_mode_pin,
  input wire logic i_freeze,
  input wire logic i_crystal_input,
  input wire logic i_cycle_active,
  input wire logic i_cycle_cpu,
  input wire logic i_cycle_external,
  input wire logic i_size_acknowledge,
  input wire logic i_autovector_request,
  input wire logic i_iack_active,
  input wire logic i_iack_last,
  input wire logic i_arbitration_seen,
  input wire logic i_halt,
  input wire logic [1:0] i_pipe_track,
  input wire logic [2:0] i_low_address,
  input wire logic i_direction,
  output logic [1:0] o_pipe_track,
  output logic o_pipe_track_oe,
  output logic [2:0] o_low_address,
  output logic o_low_address_oe,
  output logic o_direction,
  output logic o_direction_oe,
  output logic o_show_cycles,
  output logic o_ext_arbitration,
  output logic o_halt_on_grant,
  output logic o_supervisor_restrict,
  output logic o_register_block_map,
  output logic [3:0] o_arbitration_number,
  output logic o_tester_slave,
  output logic o_bus_error_signal,
  output logic o_halt_reset,
  output logic o_watchdog_reset
);

  spc_pkg::spc_config_s cfg_ff;
  spc_pkg::spc_protect_s prot_ff;
  spc_pkg::spc_status_s status;
  spc_pkg::spc_svc_e svc_ff;
  logic strap_pending_ff;
  logic map_written_ff;
  logic aw_hold_ff;
  logic w_hold_ff;
  logic [7:0] awaddr_ff;
  logic [2:0] awprot_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic commit;
  logic wr_en;
  logic [1:0] active_timing_ff;
  logic wdg_expired_ff;
  logic xtal_d_ff;
  logic wdg_expire;
  logic svc_write;
  logic svc_restart;
  logic [6:0] bm_count_ff;
  logic bm_fired_ff;
  logic [6:0] bm_limit;
  logic bm_watched;
  logic bm_done;
  logic bm_timeout;
  logic spur_timeout;
  logic arb_seen_ff;

  // Known register offsets only
  function automatic logic is_mapped(input logic [7:0] addr);
    return (addr == spc_pkg::OFS_CONFIG) || (addr == spc_pkg::OFS_PROTECT)
      || (addr == spc_pkg::OFS_SERVICE) || (addr == spc_pkg::OFS_STATUS);
  endfunction

  // User-level accesses refused while restricted
  function automatic logic is_allowed(input logic [2:0] prot,
                                      input logic restrict_on);
    return ~restrict_on | prot[0];
  endfunction

  function automatic logic [1:0] resp_for(input logic [7:0] addr,
                                          input logic [2:0] prot,
                                          input logic restrict_on);
    if (!is_mapped(addr)) begin
      return spc_pkg::RESP_DECERR;
    end else if (!is_allowed(prot, restrict_on)) begin
      return spc_pkg::RESP_SLVERR;
    end
    return spc_pkg::RESP_OKAY;
  endfunction

  // Write address, held until response taken
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      aw_hold_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      awprot_ff <= 3'h0;
    end else if (i_awvalid && o_awready) begin
      o_awready <= 1'b0;
      aw_hold_ff <= 1'b1;
      awaddr_ff <= i_awaddr;
      awprot_ff <= i_awprot;
    end else if (commit) begin
      aw_hold_ff <= 1'b0;
    end else if (o_bvalid && i_bready) begin
      o_awready <= 1'b1;
    end
  end

  // Write data, taken apart from address
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wready <= 1'b1;
      w_hold_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
    end else if (i_wvalid && o_wready) begin
      o_wready <= 1'b0;
      w_hold_ff <= 1'b1;
      wdata_ff <= i_wdata;
      wstrb_ff <= i_wstrb;
    end else if (commit) begin
      w_hold_ff <= 1'b0;
    end else if (o_bvalid && i_bready) begin
      o_wready <= 1'b1;
    end
  end

  assign commit = aw_hold_ff & w_hold_ff & ~o_bvalid;
  assign wr_en = commit & is_mapped(awaddr_ff)
    & is_allowed(awprot_ff, cfg_ff.supervisor_restrict);

  // Response one edge after both halves
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bvalid <= 1'b0;
      o_bresp <= spc_pkg::RESP_OKAY;
    end else if (commit) begin
      o_bvalid <= 1'b1;
      o_bresp <= resp_for(awaddr_ff, awprot_ff,
                          cfg_ff.supervisor_restrict);
    end else if (i_bready) begin
      o_bvalid <= 1'b0;
    end
  end

  // Status word shows watchdog state
  assign status.active_timing = active_timing_ff;
  assign status.service_armed = (svc_ff == spc_pkg::SVC_ARMED);
  assign status.watchdog_expired = wdg_expired_ff;

  // Read data loaded at address handshake
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0000_0000;
      o_rresp <= spc_pkg::RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= resp_for(i_araddr, i_arprot, cfg_ff.supervisor_restrict);
      o_rdata <= 32'h0000_0000;
      if (is_allowed(i_arprot, cfg_ff.supervisor_restrict)) begin
        case (i_araddr)
          spc_pkg::OFS_CONFIG: o_rdata <= {16'h0000, cfg_ff};
          spc_pkg::OFS_PROTECT: o_rdata <= {24'h00_0000, prot_ff};
          spc_pkg::OFS_STATUS: o_rdata <= {28'h000_0000, status};
          default: o_rdata <= 32'h0000_0000;
        endcase
      end
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Straps caught on first edge after reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      strap_pending_ff <= 1'b1;
    end else begin
      strap_pending_ff <= 1'b0;
    end
  end

  // Module configuration; strap load wins over a write
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg_ff <= spc_pkg::CONFIG_RST;
      map_written_ff <= 1'b0;
    end else if (strap_pending_ff) begin
      cfg_ff.pipeline_pins_disable <= ~i_bus_error_signal;
      cfg_ff.low_address_disable <= ~i_bus_error_signal;
      cfg_ff.direction_pin_disable <= ~i_bus_error_signal;
      cfg_ff.tester_slave_status <= ~i_data_line_eleven;
    end else if (wr_en && awaddr_ff == spc_pkg::OFS_CONFIG) begin
      if (wstrb_ff[0]) begin
        cfg_ff.arbitration_number <= wdata_ff[3:0];
        cfg_ff.direction_pin_disable <= wdata_ff[4];
        cfg_ff.low_address_disable <= wdata_ff[5];
        cfg_ff.supervisor_restrict <= wdata_ff[7];
        map_written_ff <= 1'b1;
        if (!map_written_ff) begin
          cfg_ff.register_block_map <= wdata_ff[6];
        end
      end
      if (wstrb_ff[1]) begin
        cfg_ff.show_cycle_select <= wdata_ff[9:8];
        cfg_ff.pipeline_pins_disable <= wdata_ff[12];
        cfg_ff.freeze_monitor <= wdata_ff[13];
        cfg_ff.freeze_watchdog <= wdata_ff[14];
      end
    end
  end

  // Protection control with prescale strap
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      prot_ff <= spc_pkg::PROTECT_RST;
    end else if (strap_pending_ff) begin
      prot_ff.watchdog_prescale <= ~i_clock_mode_pin;
    end else if (wr_en && awaddr_ff == spc_pkg::OFS_PROTECT
                 && wstrb_ff[0]) begin
      prot_ff <= wdata_ff[7:0];
    end
  end

  // Service sequence: arm on one key, fire on the other
  assign svc_write = wr_en & (awaddr_ff == spc_pkg::OFS_SERVICE)
    & wstrb_ff[0];
  assign svc_restart = svc_write & (svc_ff == spc_pkg::SVC_ARMED)
    & (wdata_ff[7:0] == spc_pkg::SVC_KEY_FIRE);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      svc_ff <= spc_pkg::SVC_IDLE;
    end else if (svc_write) begin
      case (svc_ff)
        spc_pkg::SVC_IDLE: begin
          if (wdata_ff[7:0] == spc_pkg::SVC_KEY_ARM) begin
            svc_ff <= spc_pkg::SVC_ARMED;
          end
        end
        spc_pkg::SVC_ARMED: begin
          // Only a repeated arm key keeps the sequence open
          if (wdata_ff[7:0] != spc_pkg::SVC_KEY_ARM) begin
            svc_ff <= spc_pkg::SVC_IDLE;
          end
        end
        default: svc_ff <= spc_pkg::SVC_IDLE;
      endcase
    end
  end

  // Divider timing, refreshed by service
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      active_timing_ff <= 2'h0;
    end else if (svc_restart) begin
      active_timing_ff <= prot_ff.watchdog_timing;
    end
  end

  // Sampled crystal must stay well below i_clk
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      xtal_d_ff <= 1'b0;
    end else begin
      xtal_d_ff <= i_crystal_input;
    end
  end

  spc_wdg_div u_wdg_div (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_clear(svc_restart | ~prot_ff.watchdog_enable),
    .i_step(i_crystal_input & ~xtal_d_ff
            & ~(i_freeze & cfg_ff.freeze_watchdog)),
    .i_high_freq(HIGH_FREQ_XTAL),
    .i_prescale(prot_ff.watchdog_prescale),
    .i_timing(active_timing_ff),
    .o_expire(wdg_expire)
  );

  // Reset request sticky until chip reset
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wdg_expired_ff <= 1'b0;
    end else if (wdg_expire && prot_ff.watchdog_enable) begin
      wdg_expired_ff <= 1'b1;
    end
  end

  // Bus monitor limit decode
  always_comb begin
    case (prot_ff.monitor_timeout_select)
      2'h0: bm_limit = spc_pkg::BM_LIMIT_00;
      2'h1: bm_limit = spc_pkg::BM_LIMIT_01;
      2'h2: bm_limit = spc_pkg::BM_LIMIT_10;
      default: bm_limit = spc_pkg::BM_LIMIT_11;
    endcase
  end

  // External cycles only if processor-started
  assign bm_watched = i_cycle_active & ~bm_fired_ff
    & (~i_cycle_external
       | (i_cycle_cpu & prot_ff.external_monitor_enable))
    & ~(i_freeze & cfg_ff.freeze_monitor);
  assign bm_done = i_size_acknowledge | i_autovector_request;
  assign bm_timeout = bm_watched & ~bm_done
    & (bm_count_ff == bm_limit - 7'h01);

  // One error per bus cycle
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      bm_count_ff <= 7'h00;
      bm_fired_ff <= 1'b0;
    end else begin
      if (!bm_watched || bm_done || bm_timeout) begin
        bm_count_ff <= 7'h00;
      end else begin
        bm_count_ff <= bm_count_ff + 7'h01;
      end
      if (!i_cycle_active) begin
        bm_fired_ff <= 1'b0;
      end else if (bm_timeout) begin
        bm_fired_ff <= 1'b1;
      end
    end
  end

  // Spurious monitor has no enable at all
  assign spur_timeout = i_iack_active & i_iack_last & ~arb_seen_ff
    & ~i_arbitration_seen;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      arb_seen_ff <= 1'b0;
    end else if (!i_iack_active || i_iack_last) begin
      arb_seen_ff <= 1'b0;
    end else if (i_arbitration_seen) begin
      arb_seen_ff <= 1'b1;
    end
  end

  // Error, halt and reset outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bus_error_signal <= 1'b0;
      o_halt_reset <= 1'b0;
      o_watchdog_reset <= 1'b0;
    end else begin
      o_bus_error_signal <= bm_timeout | spur_timeout;
      o_halt_reset <= i_halt & prot_ff.halt_reset_enable;
      o_watchdog_reset <= wdg_expired_ff | wdg_expire
        & prot_ff.watchdog_enable;
    end
  end

  // Pin drivers; disable releases pin, but freeze keeps pipeline pins driven
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pipe_track <= 2'h0;
      o_pipe_track_oe <= 1'b0;
      o_low_address <= 3'h0;
      o_low_address_oe <= 1'b0;
      o_direction <= 1'b0;
      o_direction_oe <= 1'b0;
    end else begin
      o_pipe_track <= i_pipe_track;
      o_pipe_track_oe <= ~cfg_ff.pipeline_pins_disable | i_freeze;
      o_low_address <= i_low_address;
      o_low_address_oe <= ~cfg_ff.low_address_disable;
      o_direction <= i_direction;
      o_direction_oe <= ~cfg_ff.direction_pin_disable;
    end
  end

  // Configuration outputs
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_show_cycles <= 1'b0;
      o_ext_arbitration <= 1'b1;
      o_halt_on_grant <= 1'b0;
      o_supervisor_restrict <= 1'b1;
      o_register_block_map <= 1'b1;
      o_arbitration_number <= 4'hf;
      o_tester_slave <= 1'b0;
    end else begin
      o_show_cycles <= cfg_ff.show_cycle_select != spc_pkg::SHOW_NONE;
      o_ext_arbitration <=
        cfg_ff.show_cycle_select != spc_pkg::SHOW_NO_ARB;
      o_halt_on_grant <=
        cfg_ff.show_cycle_select == spc_pkg::SHOW_HALT_GRANT;
      o_supervisor_restrict <= cfg_ff.supervisor_restrict;
      o_register_block_map <= cfg_ff.register_block_map;
      o_arbitration_number <= cfg_ff.arbitration_number;
      o_tester_slave <= cfg_ff.tester_slave_status;
    end
  end

endmodule

// *** test/spc_top_properties.sv ***
`timescale 1ns/1ns
module spc_top_properties (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_halt,
  input wire logic i_cycle_active,
  input wire logic i_iack_active,
  input wire logic i_iack_last,
  input wire logic i_arbitration_seen,
  input wire logic [1:0] i_pipe_track,
  input wire logic [2:0] i_low_address,
  input wire logic [1:0] o_pipe_track,
  input wire logic o_pipe_track_oe,
  input wire logic [2:0] o_low_address,
  input wire logic o_low_address_oe,
  input wire logic o_show_cycles,
  input wire logic o_ext_arbitration,
  input wire logic o_halt_on_grant,
  input wire logic [3:0] o_arbitration_number,
  input wire logic o_bus_error_signal,
  input wire logic o_halt_reset,
  input wire logic o_watchdog_reset
);
  logic arb_seen_ff;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Arbitration seen earlier in the same acknowledge
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      arb_seen_ff <= 1'h0;
    end else begin
      arb_seen_ff <= i_iack_active && !i_iack_last &&
        (arb_seen_ff || i_arbitration_seen);
    end
  end
  sequence s_bare_iack_end;
    i_iack_active && i_iack_last && !i_arbitration_seen && !arb_seen_ff;
  endsequence
  a_spurious_error: assert property (s_bare_iack_end |=> o_bus_error_signal)
    else $error("spurious error missing");
  a_monitor_min: assert property (o_bus_error_signal &&
    !$past(i_iack_active) |-> $past(i_cycle_active, 8))
    else $error("bus error too early");
  a_pipe_copy: assert property (o_pipe_track_oe |->
    o_pipe_track == $past(i_pipe_track))
    else $error("pipeline pins wrong");
  a_addr_copy: assert property (o_low_address_oe |->
    o_low_address == $past(i_low_address))
    else $error("low address wrong");
  a_halt_cause: assert property (o_halt_reset |-> $past(i_halt))
    else $error("halt reset without halt");
  a_show_decode: assert property ((o_show_cycles || o_ext_arbitration) &&
    (!o_halt_on_grant || (o_show_cycles && o_ext_arbitration)))
    else $error("illegal show code");
  a_arb_reset: assert property ($fell(i_rst) |->
    o_arbitration_number == 4'hf)
    else $error("arbitration number not ones");
  a_wdg_sticky: assert property (o_watchdog_reset |=> o_watchdog_reset)
    else $error("watchdog reset dropped");
endmodule
bind spc_top spc_top_properties i_props (.*);

// *** test/spc_bus_model.sv ***
`timescale 1ns/1ns
module spc_bus_model (
  input wire logic i_clk,
  output logic o_cycle_active = 1'h0,
  output logic o_cycle_cpu = 1'h0,
  output logic o_cycle_external = 1'h0,
  output logic o_size_acknowledge = 1'h0,
  output logic o_autovector_request = 1'h0,
  output logic o_iack_active = 1'h0,
  output logic o_iack_last = 1'h0,
  output logic o_arbitration_seen = 1'h0,
  output logic o_halt = 1'h0
);
  // Transfer held len clocks, acknowledged in its last clock
  task automatic cyc(input int len, input logic cpu, ext);
    @(posedge i_clk);
    o_cycle_active <= 1'h1;
    o_cycle_cpu <= cpu;
    o_cycle_external <= ext;
    repeat (len - 1) @(posedge i_clk);
    o_size_acknowledge <= 1'h1;
    @(posedge i_clk);
    o_cycle_active <= 1'h0;
    o_size_acknowledge <= 1'h0;
  endtask
  // Three-clock acknowledge; arbitration only in the middle clock
  task automatic iack(input logic arb);
    @(posedge i_clk);
    o_iack_active <= 1'h1;
    @(posedge i_clk);
    o_arbitration_seen <= arb;
    @(posedge i_clk);
    o_arbitration_seen <= 1'h0;
    o_iack_last <= 1'h1;
    o_autovector_request <= 1'h1;
    @(posedge i_clk);
    o_iack_active <= 1'h0;
    o_iack_last <= 1'h0;
    o_autovector_request <= 1'h0;
  endtask
  // Halt on the internal bus for two clocks
  task automatic hlt;
    @(posedge i_clk);
    o_halt <= 1'h1;
    repeat (2) @(posedge i_clk);
    o_halt <= 1'h0;
  endtask
endmodule

// *** test/spc_top_tb.sv ***
`timescale 1ns/1ns
module spc_top_tb;
  logic i_clk, i_rst = 1'h1, i_freeze = 1'h0, i_direction = 1'h1;
  logic i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
  logic i_arvalid = 1'h0, i_rready = 1'h0, i_bus_error_signal = 1'h0;
  logic i_data_line_eleven = 1'h0, i_clock_mode_pin = 1'h0;
  logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
  logic [2:0] i_awprot = 3'h0, i_arprot = 3'h0, i_low_address = 3'h5;
  logic [31:0] i_wdata = 32'h0, rdat, o_rdata;
  logic [3:0] i_wstrb = 4'hf, o_arbitration_number;
  logic [1:0] i_pipe_track = 2'h2, rrsp, xc = 2'h0, o_bresp, o_rresp;
  logic [1:0] o_pipe_track;
  logic [2:0] o_low_address;
  logic [2:0] shw [4] = '{3'h2, 3'h4, 3'h6, 3'h7};
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_direction;
  logic o_pipe_track_oe, o_low_address_oe, o_direction_oe, o_show_cycles;
  logic o_ext_arbitration, o_halt_on_grant, o_supervisor_restrict;
  logic o_register_block_map, o_tester_slave, o_bus_error_signal;
  logic o_halt_reset, o_watchdog_reset;
  wire i_crystal_input = xc[1];
  wire i_cycle_active, i_cycle_cpu, i_cycle_external, i_size_acknowledge;
  wire i_autovector_request, i_iack_active, i_iack_last, i_halt;
  wire i_arbitration_seen;
  int errors = 0, checks = 0, pulses = 0, halts = 0, n;
  spc_top i_dut (.*);
  spc_bus_model i_bus (.i_clk, .o_cycle_active(i_cycle_active),
    .o_cycle_cpu(i_cycle_cpu), .o_cycle_external(i_cycle_external),
    .o_size_acknowledge(i_size_acknowledge), .o_halt(i_halt),
    .o_autovector_request(i_autovector_request), .o_iack_last(i_iack_last),
    .o_iack_active(i_iack_active), .o_arbitration_seen(i_arbitration_seen));
  initial begin
    i_clk = 1'h0;
    forever #4 i_clk = ~i_clk;
  end
  // Crystal at a quarter of the clock; event counters
  always @(posedge i_clk) begin
    xc <= xc + 2'h1;
    if (o_bus_error_signal === 1'h1) pulses <= pulses + 1;
    if (o_halt_reset === 1'h1) halts <= halts + 1;
  end
  task automatic final_report;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic hang;
    errors++;
    final_report();
  endtask
  task automatic chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value at %0t: %h expected %h", $time, g, e);
    end
  endtask
  task automatic idle;
    repeat (3) @(posedge i_clk);
  endtask
  task automatic rst(input logic b, d, m);
    i_rst <= 1'h1;
    i_bus_error_signal <= b;
    i_data_line_eleven <= d;
    i_clock_mode_pin <= m;
    repeat (5) @(posedge i_clk);
    i_rst <= 1'h0;
    idle();
  endtask
  // Both write halves offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic p);
    n = 0;
    @(posedge i_clk);
    i_awvalid <= 1'h1;
    i_wvalid <= 1'h1;
    i_bready <= 1'h1;
    i_awaddr <= a;
    i_wdata <= d;
    i_awprot <= {2'h0, p};
    do begin
      @(posedge i_clk);
      n++;
      if (o_awready) i_awvalid <= 1'h0;
      if (o_wready) i_wvalid <= 1'h0;
    end while (!o_bvalid && n < 60);
    i_bready <= 1'h0;
    if (n >= 60) hang();
    idle();
  endtask
  task automatic rd(input logic [7:0] a, input logic p);
    n = 0;
    @(posedge i_clk);
    i_arvalid <= 1'h1;
    i_rready <= 1'h1;
    i_araddr <= a;
    i_arprot <= {2'h0, p};
    do begin
      @(posedge i_clk);
      n++;
      if (o_arready) i_arvalid <= 1'h0;
    end while (!o_rvalid && n < 60);
    i_rready <= 1'h0;
    rdat = o_rdata;
    rrsp = o_rresp;
    if (n >= 60) hang();
  endtask
  initial begin
    // Both strap settings; the second one is kept
    for (int i = 0; i < 2; i++) begin
      rst(i == 0, i == 0, i != 0);
      rd(8'h00, 1'h1);
      chk(rdat, i ? 32'h18ff : 32'h00cf);
      rd(8'h04, 1'h1);
      chk(rdat, i ? 32'h0 : 32'h40);
    end
    chk({o_low_address_oe, o_direction_oe, o_pipe_track_oe}, 0);
    i_freeze <= 1'h1;
    idle();
    chk({o_pipe_track_oe, o_pipe_track}, 3'h6);
    i_freeze <= 1'h0;
    rd(8'h00, 1'h0);
    chk(rrsp, spc_pkg::RESP_SLVERR);
    wr(8'h00, 32'h000f, 1'h1);
    chk(o_register_block_map, 0);
    chk({o_supervisor_restrict, o_tester_slave, o_arbitration_number,
      o_direction, o_low_address_oe, o_low_address, o_direction_oe},
      12'h7fb);
    rd(8'h00, 1'h0);
    chk(rdat, 32'h080f);
    // Every show code; a later map write is ignored
    for (int k = 0; k < 4; k++) begin
      wr(8'h00, {22'h0, k[1:0], 8'h4f}, 1'h1);
      chk({o_show_cycles, o_ext_arbitration, o_halt_on_grant}, shw[k]);
    end
    rd(8'h00, 1'h0);
    chk(rdat, 32'h0b0f);
    rd(8'h10, 1'h1);
    chk(rrsp, spc_pkg::RESP_DECERR);
    $display("test config finished");
    // Each monitor limit, just under and just over
    for (int k = 0; k < 4; k++) begin
      wr(8'h04, k, 1'h1);
      pulses = 0;
      i_bus.cyc((64 >> k) - 1, 1'h1, 1'h0);
      idle();
      chk(pulses, 0);
      i_bus.cyc((64 >> k) + 2, 1'h1, 1'h0);
      idle();
      chk(pulses != 0, 1);
    end
    pulses = 0;
    i_bus.cyc(70, 1'h0, 1'h1);
    i_bus.cyc(70, 1'h1, 1'h1);
    idle();
    chk(pulses, 0);
    wr(8'h04, 32'h04, 1'h1);
    pulses = 0;
    i_bus.cyc(70, 1'h1, 1'h1);
    idle();
    chk(pulses != 0, 1);
    pulses = 0;
    i_bus.iack(1'h1);
    i_bus.iack(1'h0);
    idle();
    chk(pulses, 1);
    i_bus.hlt();
    idle();
    chk(halts, 0);
    wr(8'h04, 32'h08, 1'h1);
    i_bus.hlt();
    idle();
    chk(halts != 0, 1);
    $display("test monitors finished");
    // Arm, cancel, retime, then let the watchdog run out
    wr(8'h04, 32'h80, 1'h1);
    wr(8'h08, 32'h55, 1'h1);
    rd(8'h0c, 1'h1);
    chk(rdat, 32'h2);
    wr(8'h08, 32'h12, 1'h1);
    rd(8'h0c, 1'h1);
    chk(rdat, 32'h0);
    wr(8'h04, 32'h90, 1'h1);
    rd(8'h0c, 1'h1);
    chk(rdat, 32'h0);
    wr(8'h08, 32'h55, 1'h1);
    wr(8'h08, 32'haa, 1'h1);
    rd(8'h0c, 1'h1);
    chk(rdat, 32'h4);
    wr(8'h04, 32'h80, 1'h1);
    wr(8'h08, 32'h55, 1'h1);
    wr(8'h08, 32'haa, 1'h1);
    for (n = 0; n < 3000 && o_watchdog_reset !== 1'h1; n++) @(posedge i_clk);
    chk(n > 2030 && n < 2066, 1);
    $display("test watchdog finished");
    final_report();
  end
endmodule
